// ### src/axis_multifunction_pins.v
// shared multifunction pins io3..io7 for each motion axis
//
// Behaviour
// - each pin carries one host-selected function
// - io7 input level readable in status word
// - io7 output drives written 1 or 0
// - io3 to io6 behave like io7
// - io3 to io7 feed synchronous-action trigger
// - decreasing-acceleration status only while decreasing
// - comparator three output follows register three
// - constant-acceleration status only while held constant
// - comparator two output follows register two
// - increasing-acceleration status only while rising
// - comparator one output follows register one
// - minus falling edge starts negative relative drive
// - minus held low gives negative continuous drive
// - minus pin is pulser B phase
// - plus falling edge starts positive relative drive
// - plus held low gives positive continuous drive
// - plus pin is pulser A phase
// - deceleration status only while decelerating
// - comparator zero output follows register zero
// - io3 emits sync pulse, set polarity, width
// - constant-speed status only at constant speed
`timescale 1ns/1ps
`include "axis_multifunction_pins_defs.vh"

module axis_multifunction_pins #(
  parameter NUM_AXES = 4,
  parameter PW_W = 8
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire [NUM_AXES*`PINS_PER_AXIS-1:0] i_pin_in,
  output reg [NUM_AXES*`PINS_PER_AXIS-1:0] o_pin_out,
  output reg [NUM_AXES*`PINS_PER_AXIS-1:0] o_pin_oe,
  input wire [NUM_AXES*`PINS_PER_AXIS*`FSEL_W-1:0] i_func_sel,
  input wire [NUM_AXES*`PINS_PER_AXIS-1:0] i_gp_out_data,
  output reg [NUM_AXES*`PINS_PER_AXIS-1:0] o_gp_in_data,
  output reg [NUM_AXES*`PINS_PER_AXIS-1:0] o_sync_trig_src,
  input wire [NUM_AXES-1:0] i_driving,
  input wire [NUM_AXES*`PHASE_W-1:0] i_phase,
  input wire [NUM_AXES*4-1:0] i_cmp_match,
  input wire [NUM_AXES*`EXT_W-1:0] i_ext_mode,
  output reg [NUM_AXES-1:0] o_ext_rel_start_plus,
  output reg [NUM_AXES-1:0] o_ext_rel_start_minus,
  output reg [NUM_AXES-1:0] o_ext_cont_plus,
  output reg [NUM_AXES-1:0] o_ext_cont_minus,
  output reg [NUM_AXES-1:0] o_pulser_a,
  output reg [NUM_AXES-1:0] o_pulser_b,
  input wire [NUM_AXES-1:0] i_sync_pulse_trig,
  input wire [NUM_AXES-1:0] i_sync_pulse_active_low,
  input wire [NUM_AXES*PW_W-1:0] i_sync_pulse_width
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // pins are taken as synchronous; one stage for levels, a second
  // stage gives the previous level for falling-edge detection
  reg [NUM_AXES*`PINS_PER_AXIS-1:0] pin_q;
  reg [NUM_AXES*`PINS_PER_AXIS-1:0] pin_prev_q;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q <= {NUM_AXES{`PIN_RST}};
      pin_prev_q <= {NUM_AXES{`PIN_RST}};
    end else begin
      pin_q <= i_pin_in;
      pin_prev_q <= pin_q;
    end
  end

  genvar a;
  genvar p;
  generate
    for (a = 0; a < NUM_AXES; a = a + 1) begin : g_axis
      wire [`PHASE_W-1:0] phase;
      wire [`EXT_W-1:0] ext_mode;
      wire [PW_W-1:0] pulse_width;
      wire [4:0] status_v;
      wire [4:0] cmp_v;
      wire [4:0] fall;
      wire [4:0] lvl;
      wire plus_ext;
      wire minus_ext;
      reg [PW_W-1:0] sync_cnt_q;
      reg [PW_W-1:0] sync_cnt_d;
      wire sync_active;

      assign phase = i_phase[a*`PHASE_W +: `PHASE_W];
      assign ext_mode = i_ext_mode[a*`EXT_W +: `EXT_W];
      assign pulse_width = i_sync_pulse_width[a*PW_W +: PW_W];
      assign lvl = pin_q[a*`PINS_PER_AXIS +: `PINS_PER_AXIS];
      assign fall = pin_prev_q[a*`PINS_PER_AXIS +: `PINS_PER_AXIS] & ~lvl;

      // ----------------------------------------------------------------
      // drive profile status
      // ----------------------------------------------------------------
      // one phase code decoded, so at most one status bit is ever high;
      // every bit is gated by the driving flag so an idle axis shows none
      assign status_v[`POS_IO3] = i_driving[a] &
        (phase == `PHASE_CONST_SPEED);
      assign status_v[`POS_IO4] = i_driving[a] &
        (phase == `PHASE_DECEL);
      assign status_v[`POS_IO5] = i_driving[a] &
        (phase == `PHASE_ACC_INC);
      assign status_v[`POS_IO6] = i_driving[a] &
        (phase == `PHASE_ACC_CONST);
      assign status_v[`POS_IO7] = i_driving[a] &
        (phase == `PHASE_ACC_DEC);

      // ----------------------------------------------------------------
      // comparator outputs
      // ----------------------------------------------------------------
      // io3 has no comparator function; its slot stays low
      assign cmp_v[`POS_IO3] = 1'b0;
      assign cmp_v[`POS_IO4] = i_cmp_match[a*4 + 0];
      assign cmp_v[`POS_IO5] = i_cmp_match[a*4 + 1];
      assign cmp_v[`POS_IO6] = i_cmp_match[a*4 + 2];
      assign cmp_v[`POS_IO7] = i_cmp_match[a*4 + 3];

      // ----------------------------------------------------------------
      // synchronous pulse on io3
      // ----------------------------------------------------------------
      // a width of zero still gives a one-cycle pulse; a new trigger
      // while a pulse runs restarts it rather than being dropped
      always @* begin
        sync_cnt_d = sync_cnt_q;
        if (i_sync_pulse_trig[a]) begin
          if (pulse_width == {PW_W{1'b0}}) begin
            sync_cnt_d = {{(PW_W-1){1'b0}}, 1'b1};
          end else begin
            sync_cnt_d = pulse_width;
          end
        end else if (sync_cnt_q != {PW_W{1'b0}}) begin
          sync_cnt_d = sync_cnt_q - {{(PW_W-1){1'b0}}, 1'b1};
        end
      end

      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync_cnt_q <= {PW_W{1'b0}};
        end else begin
          sync_cnt_q <= sync_cnt_d;
        end
      end

      assign sync_active = (sync_cnt_q != {PW_W{1'b0}});

      // ----------------------------------------------------------------
      // per-pin function multiplexer
      // ----------------------------------------------------------------
      for (p = 0; p < `PINS_PER_AXIS; p = p + 1) begin : g_pin
        // masks kept at pin width so a single bit is picked, not a shifted word
        localparam [`PINS_PER_AXIS-1:0] cmp_mask = `CMP_PIN_MASK;
        localparam [`PINS_PER_AXIS-1:0] sync_mask = `SYNC_PIN_MASK;
        wire [`FSEL_W-1:0] sel;
        reg out_d;
        reg oe_d;
        reg gp_in_d;

        assign sel = i_func_sel[(a*`PINS_PER_AXIS + p)*`FSEL_W +: `FSEL_W];

        // unsupported codes for a pin leave it released as an input
        always @* begin
          out_d = 1'b0;
          oe_d = 1'b0;
          gp_in_d = 1'b0;
          case (sel)
            `FSEL_GP_IN: begin
              gp_in_d = lvl[p];
            end
            `FSEL_GP_OUT: begin
              out_d = i_gp_out_data[a*`PINS_PER_AXIS + p];
              oe_d = 1'b1;
            end
            `FSEL_STATUS: begin
              out_d = status_v[p];
              oe_d = 1'b1;
            end
            `FSEL_CMP: begin
              out_d = cmp_v[p];
              oe_d = cmp_mask[p];
            end
            `FSEL_SYNC_PULSE: begin
              out_d = sync_mask[p] & (sync_active ^ i_sync_pulse_active_low[a]);
              oe_d = sync_mask[p];
            end
            default: begin
              out_d = 1'b0;
              oe_d = 1'b0;
            end
          endcase
        end

        always @(posedge i_clk or negedge i_arst_n) begin
          if (!i_arst_n) begin
            o_pin_out[a*`PINS_PER_AXIS + p] <= 1'b0;
            o_pin_oe[a*`PINS_PER_AXIS + p] <= 1'b0;
            o_gp_in_data[a*`PINS_PER_AXIS + p] <= 1'b0;
            o_sync_trig_src[a*`PINS_PER_AXIS + p] <= 1'b1;
          end else begin
            o_pin_out[a*`PINS_PER_AXIS + p] <= out_d;
            o_pin_oe[a*`PINS_PER_AXIS + p] <= oe_d;
            o_gp_in_data[a*`PINS_PER_AXIS + p] <= gp_in_d;
            o_sync_trig_src[a*`PINS_PER_AXIS + p] <= lvl[p];
          end
        end
      end

      // ----------------------------------------------------------------
      // external start and manual pulser
      // ----------------------------------------------------------------
      // only honoured while the pin is selected as an external input,
      // so a pin we drive can never start a drive by itself
      assign plus_ext = (i_func_sel[(a*`PINS_PER_AXIS + `POS_IO4)*`FSEL_W +: `FSEL_W]
        == `FSEL_EXT_IN);
      assign minus_ext = (i_func_sel[(a*`PINS_PER_AXIS + `POS_IO5)*`FSEL_W +: `FSEL_W]
        == `FSEL_EXT_IN);

      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_ext_rel_start_plus[a] <= 1'b0;
          o_ext_rel_start_minus[a] <= 1'b0;
          o_ext_cont_plus[a] <= 1'b0;
          o_ext_cont_minus[a] <= 1'b0;
          o_pulser_a[a] <= 1'b0;
          o_pulser_b[a] <= 1'b0;
        end else begin
          o_ext_rel_start_plus[a] <= plus_ext & (ext_mode == `EXT_RELATIVE) &
            fall[`POS_IO4];
          o_ext_rel_start_minus[a] <= minus_ext & (ext_mode == `EXT_RELATIVE) &
            fall[`POS_IO5];
          o_ext_cont_plus[a] <= plus_ext & (ext_mode == `EXT_CONTINUOUS) &
            ~lvl[`POS_IO4];
          o_ext_cont_minus[a] <= minus_ext & (ext_mode == `EXT_CONTINUOUS) &
            ~lvl[`POS_IO5];
          o_pulser_a[a] <= plus_ext & (ext_mode == `EXT_PULSER) &
            lvl[`POS_IO4];
          o_pulser_b[a] <= minus_ext & (ext_mode == `EXT_PULSER) &
            lvl[`POS_IO5];
        end
      end
    end
  endgenerate

endmodule // axis_multifunction_pins

// ### inc/axis_multifunction_pins_defs.vh
// constants for the shared axis pin multiplexer
`ifndef AXIS_MULTIFUNCTION_PINS_DEFS_VH
`define AXIS_MULTIFUNCTION_PINS_DEFS_VH

// ----------------------------------------------------------------
// pin positions inside one axis group
// ----------------------------------------------------------------
`define PINS_PER_AXIS 5
`define POS_IO3 0
`define POS_IO4 1
`define POS_IO5 2
`define POS_IO6 3
`define POS_IO7 4

// ----------------------------------------------------------------
// function select codes, 3 bits per pin
// ----------------------------------------------------------------
`define FSEL_W 3
`define FSEL_GP_IN 3'h0
`define FSEL_GP_OUT 3'h1
`define FSEL_STATUS 3'h2
`define FSEL_CMP 3'h3
`define FSEL_EXT_IN 3'h4
`define FSEL_SYNC_PULSE 3'h5

// ----------------------------------------------------------------
// pins that carry a given alternative function
// ----------------------------------------------------------------
`define CMP_PIN_MASK 5'h1E
`define EXT_PIN_MASK 5'h06
`define SYNC_PIN_MASK 5'h01

// ----------------------------------------------------------------
// drive profile phase codes, 3 bits per axis
// ----------------------------------------------------------------
`define PHASE_W 3
`define PHASE_IDLE 3'h0
`define PHASE_ACC_INC 3'h1
`define PHASE_ACC_CONST 3'h2
`define PHASE_ACC_DEC 3'h3
`define PHASE_CONST_SPEED 3'h4
`define PHASE_DECEL 3'h5

// ----------------------------------------------------------------
// external start modes, 2 bits per axis
// ----------------------------------------------------------------
`define EXT_W 2
`define EXT_OFF 2'h0
`define EXT_RELATIVE 2'h1
`define EXT_CONTINUOUS 2'h2
`define EXT_PULSER 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIN_RST 5'h1F
`define ZERO5 5'h00

`endif

// ### verification/axis_multifunction_pins_asserts.sv
// concurrent checks on the shared axis pin multiplexer
`timescale 1ns/1ps
`include "axis_multifunction_pins_defs.vh"
module axis_multifunction_pins_asserts #(
  parameter NUM_AXES = 4,
  parameter PW_W = 8
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [NUM_AXES*`PINS_PER_AXIS-1:0] i_pin_in,
  input wire logic [NUM_AXES*`PINS_PER_AXIS-1:0] o_pin_out,
  input wire logic [NUM_AXES*`PINS_PER_AXIS-1:0] o_pin_oe,
  input wire logic [NUM_AXES*`PINS_PER_AXIS*`FSEL_W-1:0] i_func_sel,
  input wire logic [NUM_AXES*`PINS_PER_AXIS-1:0] i_gp_out_data,
  input wire logic [NUM_AXES*`PINS_PER_AXIS-1:0] o_gp_in_data,
  input wire logic [NUM_AXES-1:0] i_driving,
  input wire logic [NUM_AXES*`PHASE_W-1:0] i_phase,
  input wire logic [NUM_AXES*4-1:0] i_cmp_match,
  input wire logic [NUM_AXES*`EXT_W-1:0] i_ext_mode,
  input wire logic [NUM_AXES-1:0] o_ext_rel_start_plus,
  input wire logic [NUM_AXES-1:0] o_ext_cont_plus,
  input wire logic [NUM_AXES-1:0] i_sync_pulse_trig,
  input wire logic [NUM_AXES-1:0] i_sync_pulse_active_low,
  input wire logic [NUM_AXES*PW_W-1:0] i_sync_pulse_width
);
  // ----------------------------------------------------------------
  // axis x only: the other axes share the same logic
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire rel_ok = i_ext_mode[1:0] == `EXT_RELATIVE && i_func_sel[5:3] == `FSEL_EXT_IN;
  wire cont_ok = i_ext_mode[1:0] == `EXT_CONTINUOUS && i_func_sel[5:3] == `FSEL_EXT_IN;
  sequence s_plus_fall;
    i_pin_in[1] ##1 !i_pin_in[1] && rel_ok ##1 rel_ok;
  endsequence
  sequence s_sync_go;
    i_sync_pulse_trig[0] && i_func_sel[2:0] == `FSEL_SYNC_PULSE &&
      i_sync_pulse_width[7:0] == 8'h02 && !i_sync_pulse_active_low[0];
  endsequence
  property p_gp_out;
    $past(i_func_sel[14:12]) == `FSEL_GP_OUT |->
      o_pin_oe[4] && o_pin_out[4] == $past(i_gp_out_data[4]);
  endproperty
  property p_oe;
    o_pin_oe[1] == ($past(i_func_sel[5:3]) inside {`FSEL_GP_OUT, `FSEL_STATUS, `FSEL_CMP});
  endproperty
  property p_gp_in;
    $past(i_func_sel[14:12]) == `FSEL_GP_IN |-> o_gp_in_data[4] == $past(i_pin_in[4], 2);
  endproperty
  property p_decel;
    $past(i_func_sel[5:3]) == `FSEL_STATUS |->
      o_pin_out[1] == ($past(i_driving[0]) && $past(i_phase[2:0]) == `PHASE_DECEL);
  endproperty
  property p_acc_dec;
    $past(i_func_sel[14:12]) == `FSEL_STATUS |->
      o_pin_out[4] == ($past(i_driving[0]) && $past(i_phase[2:0]) == `PHASE_ACC_DEC);
  endproperty
  property p_comparator_zero_out;
    $past(i_func_sel[5:3]) == `FSEL_CMP |-> o_pin_out[1] == $past(i_cmp_match[0]);
  endproperty
  property p_rel_plus;
    s_plus_fall |=> o_ext_rel_start_plus[0] ##1 !o_ext_rel_start_plus[0];
  endproperty
  property p_cont_plus;
    (cont_ok && !i_pin_in[1]) [*2] |=> o_ext_cont_plus[0];
  endproperty
  property p_sync;
    s_sync_go |-> ##2 o_pin_out[0] [*2] ##1 !o_pin_out[0];
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("gp output wrong");
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  a_gp_in: assert property (p_gp_in) else $error("gp input wrong");
  a_decel: assert property (p_decel) else $error("decel status wrong");
  a_acc_dec: assert property (p_acc_dec) else $error("accel down status wrong");
  a_comparator_zero_out: assert property (p_comparator_zero_out) else $error("comparator zero wrong");
  a_rel_plus: assert property (p_rel_plus) else $error("plus start wrong");
  a_cont_plus: assert property (p_cont_plus) else $error("plus run wrong");
  a_sync: assert property (p_sync) else $error("sync pulse wrong");
endmodule // axis_multifunction_pins_asserts

bind axis_multifunction_pins axis_multifunction_pins_asserts #(
  .NUM_AXES(NUM_AXES), .PW_W(PW_W)) axis_multifunction_pins_asserts_inst (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .i_func_sel(i_func_sel), .i_gp_out_data(i_gp_out_data),
  .o_gp_in_data(o_gp_in_data), .i_driving(i_driving), .i_phase(i_phase),
  .i_cmp_match(i_cmp_match), .i_ext_mode(i_ext_mode),
  .o_ext_rel_start_plus(o_ext_rel_start_plus), .o_ext_cont_plus(o_ext_cont_plus),
  .i_sync_pulse_trig(i_sync_pulse_trig), .i_sync_pulse_active_low(i_sync_pulse_active_low),
  .i_sync_pulse_width(i_sync_pulse_width));

// ### verification/pin_party_model.sv
// switches, servo drivers and pulser encoder on the shared pins
`timescale 1ns/1ps
module pin_party_model #(
  parameter N = 20
) (
  input wire logic [N-1:0] i_pin_out,
  input wire logic [N-1:0] i_pin_oe,
  input wire logic [N-1:0] i_level,
  output wire logic [N-1:0] o_pin
);
  // a released pin shows the outside level, never a stale device drive
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_level);
endmodule // pin_party_model

// ### verification/tb.sv
// self-checking bench for the shared axis pin multiplexer
`timescale 1ns/1ps
`include "axis_multifunction_pins_defs.vh"
module tb;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [19:0] pin, pin_out, pin_oe, gp_in, trig_src, lvl = 20'h00000, gp_out = 20'h00000;
  logic [59:0] sel = 60'h0;
  logic [3:0] rel_p, rel_m, cont_p, cont_m, pa, pb, drv = 4'h0, strig = 4'h0, alow = 4'h0;
  logic [11:0] phase = 12'h000;
  logic [15:0] cmp = 16'h0000;
  logic [7:0] mode = 8'h00;
  logic [31:0] width = 32'h00000000;
  logic b;
  int err_count = 0;
  int cmp_count = 0;
  always #5 i_clk = ~i_clk;
  axis_multifunction_pins axis_multifunction_pins_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin_in(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_func_sel(sel), .i_gp_out_data(gp_out), .o_gp_in_data(gp_in), .o_sync_trig_src(trig_src),
    .i_driving(drv), .i_phase(phase), .i_cmp_match(cmp), .i_ext_mode(mode),
    .o_ext_rel_start_plus(rel_p), .o_ext_rel_start_minus(rel_m), .o_ext_cont_plus(cont_p),
    .o_ext_cont_minus(cont_m), .o_pulser_a(pa), .o_pulser_b(pb), .i_sync_pulse_trig(strig),
    .i_sync_pulse_active_low(alow), .i_sync_pulse_width(width));
  pin_party_model pin_party_model_inst (
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_level(lvl), .o_pin(pin));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [4:0] st(input logic [2:0] ph);
    case (ph)
      `PHASE_CONST_SPEED: st = 5'h01;
      `PHASE_DECEL: st = 5'h02;
      `PHASE_ACC_INC: st = 5'h04;
      `PHASE_ACC_CONST: st = 5'h08;
      `PHASE_ACC_DEC: st = 5'h10;
      default: st = 5'h00;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    step(8);
    i_arst_n = 1'b1;
    sel = {20{`FSEL_GP_OUT}};
    for (int k = 0; k < 2; k++) begin
      gp_out = k ? 20'h5A5A5 : 20'hA5A5A;
      step(1);
      chk(pin_out, gp_out);
      chk(pin_oe, 20'hFFFFF);
    end
    step(1);
    chk(gp_in, 20'h00000);
    $display("test 1 done");
    sel = {20{`FSEL_GP_IN}};
    lvl = 20'h3C96F;
    step(3);
    chk(pin_oe, 20'h00000);
    chk(gp_in, lvl);
    chk(trig_src, lvl);
    $display("test 2 done");
    sel = {20{`FSEL_STATUS}};
    drv = 4'hF;
    for (int p = 0; p < 6; p++) begin
      phase = {4{3'(p)}};
      step(1);
      chk(pin_out, {4{st(3'(p))}});
    end
    drv = 4'h0;
    step(1);
    chk(pin_out, 20'h00000);
    $display("test 3 done");
    sel = {4{{4{`FSEL_CMP}}, `FSEL_GP_IN}};
    for (int k = 0; k < 4; k++) begin
      cmp = {4{4'(1 << k)}};
      step(1);
      chk(pin_out, {4{5'(2 << k)}});
      chk(pin_oe, {4{5'h1E}});
    end
    $display("test 4 done");
    sel = {4{`FSEL_GP_IN, `FSEL_GP_IN, `FSEL_EXT_IN, `FSEL_EXT_IN, `FSEL_GP_IN}};
    mode = {4{`EXT_RELATIVE}};
    lvl = {4{5'h06}};
    step(3);
    lvl = {4{5'h04}};
    step(2);
    chk({12'h000, rel_p, rel_m}, 20'h000F0);
    step(1);
    chk({12'h000, rel_p, rel_m}, 20'h00000);
    lvl = 20'h00000;
    step(2);
    chk({12'h000, rel_p, rel_m}, 20'h0000F);
    step(1);
    chk({12'h000, rel_p, rel_m}, 20'h00000);
    mode = {4{`EXT_CONTINUOUS}};
    lvl = {4{5'h02}};
    step(2);
    chk({12'h000, cont_p, cont_m}, 20'h0000F);
    lvl = {4{5'h04}};
    step(2);
    chk({12'h000, cont_p, cont_m}, 20'h000F0);
    mode = {4{`EXT_PULSER}};
    step(2);
    chk({12'h000, pa, pb}, 20'h0000F);
    lvl = {4{5'h02}};
    step(2);
    chk({12'h000, pa, pb}, 20'h000F0);
    $display("test 5 done");
    sel = {4{{4{`FSEL_GP_IN}}, `FSEL_SYNC_PULSE}};
    lvl = 20'h00000;
    for (int m = 0; m < 2; m++) begin
      alow = m ? 4'hF : 4'h0;
      width = m ? {4{8'h01}} : {4{8'h02}};
      step(2);
      chk(pin_oe, {4{5'h01}});
      strig = 4'hF;
      step(1);
      strig = 4'h0;
      for (int i = 0; i < 4; i++) begin
        b = 1'(((m ? 4'h2 : 4'h6) >> i) & 4'h1);
        chk(pin_out, {4{4'h0, b ^ alow[0]}});
        step(1);
      end
    end
    $display("test 6 done");
    stop_test;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule // tb
